// >>> hw/cgp_map.svh
`ifndef CGP_MAP_SVH
`define CGP_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CGP_ADDR_WAIT_CLOCK_CONTROL 4'h0
`define CGP_ADDR_STATUS 4'h4
`define CGP_WCC_RESET 8'h08
`define CGP_BIT_RAM_SELECT 7
`define CGP_BIT_RAM_AREA 6
`define CGP_BIT_HALVE 5
`define CGP_BIT_FLASH_EN 4
`define CGP_BIT_WMODE_HI 3
`define CGP_BIT_WMODE_LO 2
`define CGP_BIT_WCOUNT_HI 1
`define CGP_BIT_WCOUNT_LO 0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CGP_CLOCK_MHZ 100
`define CGP_SETTLE_US 500
`define CGP_SETTLE_CYCLES (`CGP_SETTLE_US * `CGP_CLOCK_MHZ)
`define CGP_DUTY_MIN_MHZ 5
`define CGP_PRESCALE_BITS 12

`endif

// >>> hw/cgp_pkg.sv
package cgp_pkg;
  typedef enum logic [1:0] {
    CGP_WAIT_PROGRAMMABLE,
    CGP_WAIT_NONE,
    CGP_WAIT_PIN,
    CGP_WAIT_PIN_AUTO
  } cgp_wait_mode_t;
  typedef enum logic [1:0] {
    CGP_AX_IDLE,
    CGP_AX_RESP
  } cgp_bus_state_t;
endpackage

// >>> hw/cgp_prescaler.sv
`include "cgp_map.svh"

// Free-running prescaler; counts only on peripheral clock enable cycles.
module cgp_prescaler
  import cgp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic periph_en,
  output logic [`CGP_PRESCALE_BITS-1:0] tick
);
  logic [`CGP_PRESCALE_BITS-1:0] count;
  logic [`CGP_PRESCALE_BITS-1:0] next_count;
  logic [`CGP_PRESCALE_BITS-1:0] next_tick;

  // ----------------------------------------------------------------------------
  // Counter and enables
  // ----------------------------------------------------------------------------
  always_comb begin
    next_count = periph_en ? count + 1'b1 : count;
  end

  // Tap k pulses once every 2^(k+1) peripheral cycles: ratios 1/2 .. 1/4096.
  for (genvar k = 0; k < `CGP_PRESCALE_BITS; k++) begin : g_tap
    assign next_tick[k] = periph_en && (&count[k:0]); // [RULE_11]
  end

  // Registered so each enable is a clean single-cycle pulse.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      tick <= '0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule

// >>> hw/cgp_clock_generator.sv
// The register offsets and the AXI4-Lite slave port were decided locally.
`include "cgp_map.svh"

// Overview of operation
// RULE_01: The system clock runs at the input clock rate with no multiplication or division.
// RULE_02: Halve bit 5 clear gives a peripheral enable every cycle, set gives every other cycle.
// RULE_03: Reset and hardware standby load the control register with 0x08.
// RULE_04: Software standby leaves every control register bit untouched.
// RULE_05: Bit 4 is plain read/write storage resetting to 0.
// RULE_06: Bits 7 and 6 are read/write RAM area select storage resetting to 0.
// RULE_07: Bits 3 to 0 are read/write wait mode and count storage fed to the wait logic.
// RULE_08: The clock is reported valid only after 500 us of settling following reset.
// RULE_09: The outside party holds reset low through the settling interval.
// RULE_10: Duty correction applies at 5 MHz and above; the synchronous clock is already clean.
// RULE_11: A prescaler derives enables from one half down to one 4096th of the peripheral rate.
// RULE_12: Changing the halve bit switches only on a phase boundary, never truncating a phase.
module cgp_clock_generator
  import cgp_pkg::*;
#(
  parameter int SETTLE_CYCLES = `CGP_SETTLE_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic periph_clk_en,
  output logic [`CGP_PRESCALE_BITS-1:0] prescale_en,
  output logic [1:0] wait_mode,
  output logic [1:0] wait_count,
  output logic emul_ram_select,
  output logic emul_ram_area,
  output logic flash_regs_enable,
  output logic clock_valid
);
  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic [7:0] wait_clock_control;
  logic [7:0] next_wait_clock_control;
  logic hw_standby_meta;
  logic hw_standby_sync;
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [3:0] aw_addr;
  logic [3:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic halve_active;
  logic next_halve_active;
  logic phase;
  logic next_phase;
  logic next_periph_clk_en;
  logic [31:0] settle_count;
  logic [31:0] next_settle_count;
  logic next_clock_valid;
  logic next_awready;
  logic next_wready;
  logic next_arready;
  cgp_bus_state_t wr_state;
  cgp_bus_state_t next_wr_state;

  // Maps a bus address to the control register word; shared by read and write.
  function automatic logic is_ctrl(input logic [3:0] addr);
    return addr == `CGP_ADDR_WAIT_CLOCK_CONTROL;
  endfunction

  function automatic logic is_status(input logic [3:0] addr);
    return addr == `CGP_ADDR_STATUS;
  endfunction

  // ----------------------------------------------------------------------------
  // Standby pin synchroniser
  // ----------------------------------------------------------------------------
  // Standby comes from a pin, so it passes two flops before any logic.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hw_standby_meta <= 1'b0;
      hw_standby_sync <= 1'b0;
    end else begin
      hw_standby_meta <= hw_standby;
      hw_standby_sync <= hw_standby_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite write path and control register
  // ----------------------------------------------------------------------------
  // Address and data are latched independently so either may come first.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_wr_state = wr_state;
    next_wait_clock_control = wait_clock_control;
    unique case (wr_state)
      CGP_AX_IDLE: begin
        if (s_axi_awvalid && !aw_held) begin
          next_aw_held = 1'b1;
          next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
          next_w_held = 1'b1;
          next_w_data = s_axi_wdata;
          next_w_lane0 = s_axi_wstrb[0];
        end
        if (aw_held && w_held) begin
          // Unmapped or read-only words answer SLVERR and store nothing.
          if (is_ctrl(aw_addr)) begin
            if (w_lane0) begin
              next_wait_clock_control = w_data[7:0]; // [RULE_05] [RULE_06] [RULE_07]
            end
            next_bresp = 2'h0;
          end else begin
            next_bresp = 2'h2;
          end
          next_bvalid = 1'b1;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_wr_state = CGP_AX_RESP;
        end
      end
      CGP_AX_RESP: begin
        if (s_axi_bready) begin
          next_bvalid = 1'b0;
          next_wr_state = CGP_AX_IDLE;
        end
      end
    endcase
    // Software standby has no term here, so contents simply persist.
    if (hw_standby_sync) begin
      next_wait_clock_control = `CGP_WCC_RESET; // [RULE_03] [RULE_04]
    end
    // Ready is offered only while the channel is empty, so each beat lands once.
    // It is taken from the next state so that the port leaves a flop.
    next_awready = (next_wr_state == CGP_AX_IDLE) && !next_aw_held;
    next_wready = (next_wr_state == CGP_AX_IDLE) && !next_w_held;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_clock_control <= `CGP_WCC_RESET; // [RULE_03]
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      wr_state <= CGP_AX_IDLE;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      wait_clock_control <= next_wait_clock_control;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      wr_state <= next_wr_state;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------------
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        next_rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp = 2'h0;
      if (is_ctrl(s_axi_araddr)) begin
        next_rdata = {24'h0, wait_clock_control};
      end else if (is_status(s_axi_araddr)) begin
        next_rdata = {30'h0, halve_active, clock_valid};
      end else begin
        next_rdata = 32'h0;
        next_rresp = 2'h2;
      end
    end
    // A new address is accepted only once the previous answer has left.
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_arready <= next_arready;
    end
  end

  // ----------------------------------------------------------------------------
  // Peripheral clock enable
  // ----------------------------------------------------------------------------
  // The system clock is the input clock itself, so no duty fix-up is needed
  // here; the halved rate is an enable, never a gated clock.
  // The mode change waits for the end of a halved phase pair so no enable
  // period is ever shortened.
  always_comb begin
    next_phase = halve_active ? !phase : 1'b0; // [RULE_01] [RULE_10]
    next_halve_active = halve_active;
    if (!halve_active || phase) begin
      next_halve_active = wait_clock_control[`CGP_BIT_HALVE]; // [RULE_12]
      next_phase = 1'b0;
    end
    next_periph_clk_en = !next_halve_active || next_phase; // [RULE_02]
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      halve_active <= 1'b0;
      phase <= 1'b0;
      periph_clk_en <= 1'b1;
    end else begin
      halve_active <= next_halve_active;
      phase <= next_phase;
      periph_clk_en <= next_periph_clk_en;
    end
  end

  cgp_prescaler u_prescaler (
    .clock(clock),
    .nrst(nrst),
    .periph_en(periph_clk_en),
    .tick(prescale_en)
  );

  // ----------------------------------------------------------------------------
  // Settling timer
  // ----------------------------------------------------------------------------
  // Reset is held by the board across settling; this timer is the device's
  // own guard so downstream logic never trusts an early clock.
  always_comb begin
    next_settle_count = settle_count;
    next_clock_valid = clock_valid;
    if (settle_count < 32'(SETTLE_CYCLES)) begin
      next_settle_count = settle_count + 32'h1; // [RULE_08] [RULE_09]
    end else begin
      next_clock_valid = 1'b1; // [RULE_08]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      settle_count <= 32'h0;
      clock_valid <= 1'b0;
    end else begin
      settle_count <= next_settle_count;
      clock_valid <= next_clock_valid;
    end
  end

  // Register fields to the wait-state logic and flash/RAM users.
  assign wait_mode = wait_clock_control[`CGP_BIT_WMODE_HI:`CGP_BIT_WMODE_LO]; // [RULE_07]
  assign wait_count = wait_clock_control[`CGP_BIT_WCOUNT_HI:`CGP_BIT_WCOUNT_LO];
  assign emul_ram_select = wait_clock_control[`CGP_BIT_RAM_SELECT]; // [RULE_06]
  assign emul_ram_area = wait_clock_control[`CGP_BIT_RAM_AREA];
  assign flash_regs_enable = wait_clock_control[`CGP_BIT_FLASH_EN]; // [RULE_05]
endmodule

// >>> sim/cgp_monitor.sv
// ----------------------------------------------------------------------------
// Port checker for the clock generator
// ----------------------------------------------------------------------------
module cgp_monitor
  import cgp_pkg::*;
#(
  parameter int SETTLE_CYCLES = 20
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic hw_standby,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic periph_clk_en,
  input wire logic [11:0] prescale_en,
  input wire logic [1:0] wait_mode,
  input wire logic [1:0] wait_count,
  input wire logic emul_ram_select,
  input wire logic emul_ram_area,
  input wire logic flash_regs_enable,
  input wire logic clock_valid
);
  int cnt;
  int next_cnt;
  logic [6:0] regs;

  // Cycles since reset release; saturates so a long run cannot wrap it.
  always_comb begin
    next_cnt = (cnt < 1000000) ? cnt + 1 : cnt;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
    end else begin
      cnt <= next_cnt;
    end
  end
  assign regs = {emul_ram_select, emul_ram_area, flash_regs_enable, wait_mode, wait_count};

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Standby pin passes two sync flops, so four high samples guarantee a reload.
  a_standby_reload: assert property (hw_standby [*4] |=> regs == 7'h08)
    else $error("control fields not reloaded in hardware standby");
  a_change_has_cause: assert property ($changed(regs) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || s_axi_bvalid ||
    $past(hw_standby, 2) || $past(hw_standby, 3) || $past(hw_standby, 4))
    else $error("control fields changed without a write or standby");
  a_periph_no_gap: assert property (!periph_clk_en |=> periph_clk_en)
    else $error("peripheral enable low for two cycles");
  a_prescale_half: assert property (prescale_en[0] |=> !prescale_en[0])
    else $error("half-rate prescale pulse too close");
  a_prescale_quarter: assert property (prescale_en[1] |=> !prescale_en[1] [*3])
    else $error("quarter-rate prescale pulse too close");
  a_valid_sticky: assert property (clock_valid |=> clock_valid)
    else $error("clock valid dropped");
  a_valid_not_early: assert property (clock_valid |-> cnt >= SETTLE_CYCLES + 1)
    else $error("clock valid before settling interval");
  a_valid_on_time: assert property (cnt >= SETTLE_CYCLES + 1 |-> clock_valid)
    else $error("clock valid late");
  // A slower tap may only pulse together with every faster one.
  a_prescale_nested: assert property (((prescale_en + 12'h1) & prescale_en) == 12'h0)
    else $error("prescale taps not nested");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");

  c_valid: cover property ($rose(clock_valid));
  c_halved: cover property (!periph_clk_en);
  c_standby: cover property (hw_standby [*4]);
endmodule

bind cgp_clock_generator cgp_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (
  .clock(clock), .nrst(nrst), .hw_standby(hw_standby), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .periph_clk_en(periph_clk_en), .prescale_en(prescale_en), .wait_mode(wait_mode),
  .wait_count(wait_count), .emul_ram_select(emul_ram_select), .emul_ram_area(emul_ram_area),
  .flash_regs_enable(flash_regs_enable), .clock_valid(clock_valid));

// >>> sim/cgp_clock_source.sv
// ----------------------------------------------------------------------------
// External clock source and board reset
// ----------------------------------------------------------------------------
module cgp_clock_source (
  output logic clock,
  output logic nrst
);
  timeunit 1ns;
  timeprecision 1ps;
  // Steady 100 MHz source; the system clock follows it one to one.
  initial clock = 1'b0;
  always #5 clock = ~clock;
  // Reset is held past the minimum pulse width while the clock settles.
  initial begin
    nrst = 1'b0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
  end
endmodule

// >>> sim/cgp_clock_generator_tb_top.sv
// ----------------------------------------------------------------------------
// Self-checking bench for the clock generator
// ----------------------------------------------------------------------------
module cgp_clock_generator_tb_top;
  import cgp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, nrst;
  logic hw_standby = 1'b0, sw_standby = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pce, rsel, rarea, fen, cvalid;
  logic [1:0] bresp, rresp, wmode, wcount;
  logic [31:0] rdata;
  logic [11:0] pre;
  int errors = 0, n_tests = 0, cycles = 0;

  cgp_clock_source src (.clock(clock), .nrst(nrst));
  cgp_clock_generator #(.SETTLE_CYCLES(20)) DUT (
    .clock(clock), .nrst(nrst), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_clk_en(pce), .prescale_en(pre), .wait_mode(wmode), .wait_count(wcount),
    .emul_ram_select(rsel), .emul_ram_area(rarea), .flash_regs_enable(fen),
    .clock_valid(cvalid));

  task automatic wrap_up;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Readies are sampled at the falling edge, when they are settled for the next rise.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    int t;
    hb = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 50 && !hb; t++) begin
      @(negedge clock);
      ha = awready;
      hw = wready;
      hb = bvalid;
      r = bresp;
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    int t;
    hr = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 50 && !hr; t++) begin
      @(negedge clock);
      ha = arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    chk("rresp", {30'h0, er}, {30'h0, r});
    chk("rdata", ed, d);
  endtask

  // Counts enables and the two fastest prescale pulses over n settled cycles.
  task automatic rates(input int n, input int ep, input int e0, input int e1);
    int a, b, c;
    a = 0;
    b = 0;
    c = 0;
    repeat (n) begin
      @(negedge clock);
      if (pce === 1'b1) a++;
      if (pre[0] === 1'b1) b++;
      if (pre[1] === 1'b1) c++;
    end
    chk("periph_clk_en count", ep, a);
    chk("prescale_en0 count", e0, b);
    chk("prescale_en1 count", e1, c);
  endtask

  task automatic t_reset;
    chk("clock_valid early", 0, cvalid);
    chk("fields", 32'h08, {rsel, rarea, fen, wmode, wcount});
    rd(4'h0, 32'h08, 2'b00);
    repeat (30) @(negedge clock);
    chk("clock_valid", 1, cvalid);
    rd(4'h4, 32'h1, 2'b00);
  endtask

  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 8'(i * 5), 2'b00);
      @(negedge clock);
      chk("wait fields", i * 5, {wmode, wcount});
      rd(4'h0, i * 5, 2'b00);
    end
    wr(4'h0, 8'hD0, 2'b00);
    @(negedge clock);
    chk("ram and flash bits", 32'h70, {rsel, rarea, fen, wmode, wcount});
    rd(4'h0, 32'hD0, 2'b00);
  endtask

  task automatic t_halve;
    wr(4'h0, 8'h20, 2'b00);
    repeat (4) @(posedge clock);
    rates(40, 20, 10, 5);
    rd(4'h4, 32'h3, 2'b00);
    wr(4'h0, 8'h00, 2'b00);
    repeat (4) @(posedge clock);
    rates(40, 40, 20, 10);
  endtask

  task automatic t_standby;
    wr(4'h0, 8'hA5, 2'b00);
    sw_standby <= 1'b1;
    repeat (10) @(posedge clock);
    rd(4'h0, 32'hA5, 2'b00);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    repeat (6) @(posedge clock);
    hw_standby <= 1'b0;
    repeat (4) @(posedge clock);
    rd(4'h0, 32'h08, 2'b00);
    rates(40, 40, 20, 10);
  endtask

  task automatic t_unmapped;
    rd(4'hC, 32'h0, 2'b10);
    wr(4'h8, 8'h55, 2'b10);
    wr(4'h4, 8'h55, 2'b10);
    rd(4'h0, 32'h08, 2'b00);
  endtask

  // A hung handshake is cut short well beyond the few hundred cycles needed.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    @(posedge nrst);
    @(negedge clock);
    t_reset();
    t_fields();
    t_halve();
    t_standby();
    t_unmapped();
    wrap_up();
  end
endmodule
